// ===== src/lsecb_top.v
// lin/uart status flags, error detection, checksum, identifier status and frame buffer
`timescale 1ns/1ps
`include "lsecb_regs.vh"
module lsecb_top #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    // clock and reset
    input wire CLK_SYS_IN,
    input wire RST_IN,
    input wire SW_RESET_IN,
    // configuration
    input wire UART_MODE_IN,
    input wire PROTOCOL_OLD_IN,
    input wire TIMEOUT_DISABLE_IN,
    input wire SLAVE_MODE_IN,
    input wire [3:0] IRQ_ENABLE_IN,
    // software commands and writes
    input wire CMD_WR_IN,
    input wire [2:0] CMD_IN,
    input wire BUSY_IN,
    input wire LEN_WR_IN,
    input wire [7:0] LEN_WDATA_IN,
    input wire [3:0] FLAG_CLEAR_IN,
    input wire INDEX_WR_IN,
    input wire [2:0] INDEX_IN,
    input wire INC_DISABLE_N_IN,
    input wire DATA_RD_IN,
    input wire DATA_WR_IN,
    input wire [7:0] DATA_WDATA_IN,
    // events from the link sequencer
    input wire FRAME_START_IN,
    input wire BIT_TICK_IN,
    input wire HDR_DONE_IN,
    input wire [7:0] PID_IN,
    input wire SYNC_TOL_ERR_IN,
    input wire STOP_SAMPLE_IN,
    input wire STOP_LEVEL_IN,
    input wire TX_BIT_CHECK_IN,
    input wire TX_BIT_SENT_IN,
    input wire RX_BIT_IN,
    input wire TX_BYTE_DONE_IN,
    input wire BREAK_SYNC_IN,
    input wire RX_VALID_IN,
    input wire [7:0] RX_BYTE_IN,
    output wire RX_READY_OUT,
    // status and data toward software
    output reg [2:0] COMMAND_OUT,
    output reg [3:0] RX_LENGTH_OUT,
    output reg [3:0] TX_LENGTH_OUT,
    output reg [3:0] FLAGS_OUT,
    output reg [7:0] ERROR_FLAGS_OUT,
    output reg [2:0] FRAME_STATUS_OUT,
    output reg [2:0] INDEX_OUT,
    output reg [7:0] DATA_RDATA_OUT,
    output reg [7:0] TX_DATA_OUT,
    output reg TX_ABORT_OUT,
    output reg IRQ_COMPLETE_OUT,
    output reg IRQ_ERROR_OUT
);
    reg [7:0] frame_buf [0:7];
    reg [7:0] sum_reg;
    reg [3:0] expect_reg;
    reg rx_resp_reg;
    reg tx_resp_reg;
    reg bit_err_pend_reg;
    reg uart_full_reg;
    reg [7:0] uart_rx_reg;
    reg [7:0] uart_tx_reg;
    reg frame_run_reg;
    reg [11:0] bit_cnt_reg;
    reg [7:0] err_set;
    reg [7:0] err_next;
    reg [3:0] ok_set;
    reg [3:0] ok_next;
    wire rst;
    wire fifo_valid;
    wire fifo_ready;
    wire [7:0] fifo_data;
    wire take_byte;
    wire cmd_ok;
    wire lin_err;
    wire data_wr_ok;
    wire [7:0] pid_calc;
    wire [11:0] frame_limit;
    wire [3:0] rx_len_clamp;
    wire [3:0] tx_len_clamp;
    wire [7:0] sum_pid;

    // carry-wrapped eight bit add
    function [7:0] add_wrap;
        input [7:0] a;
        input [7:0] b;
        reg [8:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            add_wrap = s[7:0] + {7'h00, s[8]};
        end
    endfunction

    // older protocol length from identifier bits 5:4
    function [3:0] old_len;
        input [1:0] code;
        begin
            case (code)
                2'h2: old_len = 4'h4;
                2'h3: old_len = `LSECB_LEN_MAX;
                default: old_len = 4'h2;
            endcase
        end
    endfunction

    assign rst = RST_IN | SW_RESET_IN;
    // buffer has one write port; software writes stall the fifo drain
    assign fifo_ready = ~data_wr_ok;
    assign take_byte = fifo_valid & fifo_ready;
    assign data_wr_ok = DATA_WR_IN & ~BUSY_IN;
    assign cmd_ok = CMD_WR_IN & ~BUSY_IN;
    assign lin_err = ~UART_MODE_IN & (err_set != 8'h00);
    assign rx_len_clamp = (RX_LENGTH_OUT > `LSECB_LEN_MAX) ? `LSECB_LEN_MAX : RX_LENGTH_OUT;
    assign tx_len_clamp = (TX_LENGTH_OUT > `LSECB_LEN_MAX) ? `LSECB_LEN_MAX : TX_LENGTH_OUT;
    // enhanced start value: identifier included unless older protocol
    assign sum_pid = PROTOCOL_OLD_IN ? 8'h00 : PID_IN;
    // expected parity bits for the received identifier
    assign pid_calc = {~(PID_IN[1] ^ PID_IN[3] ^ PID_IN[4] ^ PID_IN[5]),
                       PID_IN[0] ^ PID_IN[1] ^ PID_IN[2] ^ PID_IN[4], PID_IN[5:0]};
    // maximum frame in bit times: 1.4 * (34 + 10 * (n + 1))
    assign frame_limit = (`LSECB_TO_TENTHS * (`LSECB_HDR_BITS + `LSECB_BYTE_BITS *
                         ({8'h00, expect_reg} + 12'h001))) / `LSECB_TENTHS;

    // received bytes wait here for the frame buffer
    lsecb_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_in(CLK_SYS_IN),
        .rst_in(rst),
        .in_valid_in(RX_VALID_IN),
        .in_ready_out(RX_READY_OUT),
        .in_data_in(RX_BYTE_IN),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_ready),
        .out_data_out(fifo_data)
    );

    // error events of this cycle
    always @*
    begin
        err_set = 8'h00;
        ok_set = 4'h0;
        if (UART_MODE_IN)
        begin
            if (take_byte)
            begin
                ok_set[`LSECB_F_RXOK] = 1'b1;
                err_set[`LSECB_E_OVR] = uart_full_reg & ~(DATA_RD_IN);
            end
            if (TX_BYTE_DONE_IN)
                ok_set[`LSECB_F_TXOK] = 1'b1;
        end
        else
        begin
            if (HDR_DONE_IN)
            begin
                ok_set[`LSECB_F_IDOK] = 1'b1;
                err_set[`LSECB_E_PAR] = (pid_calc != PID_IN);
            end
            if (SYNC_TOL_ERR_IN & SLAVE_MODE_IN)
                err_set[`LSECB_E_SYNC] = 1'b1;
            if (CMD_WR_IN & BUSY_IN)
            begin
                err_set[`LSECB_E_OVR] = (CMD_IN != `LSECB_CMD_ABORT);
                err_set[`LSECB_E_ABORT] = (CMD_IN == `LSECB_CMD_ABORT);
            end
            // bit mismatch posted only when the byte has been serialised
            if (TX_BYTE_DONE_IN & tx_resp_reg)
            begin
                if (bit_err_pend_reg | (TX_BIT_CHECK_IN & (TX_BIT_SENT_IN != RX_BIT_IN)))
                    err_set[`LSECB_E_BIT] = 1'b1;
                else if (RX_LENGTH_OUT >= expect_reg)
                    ok_set[`LSECB_F_TXOK] = 1'b1;
            end
            if (take_byte & rx_resp_reg & (TX_LENGTH_OUT >= expect_reg))
            begin
                if (add_wrap(sum_reg, fifo_data) != `LSECB_CSUM_OK)
                    err_set[`LSECB_E_CSUM] = 1'b1;
                else
                    ok_set[`LSECB_F_RXOK] = 1'b1;
            end
            if (frame_run_reg & ~TIMEOUT_DISABLE_IN & (bit_cnt_reg > frame_limit))
                err_set[`LSECB_E_TOUT] = 1'b1;
            // break in data while a slave answers
            if (BREAK_SYNC_IN & SLAVE_MODE_IN)
            begin
                err_set[`LSECB_E_BIT] = err_set[`LSECB_E_BIT] | tx_resp_reg;
                err_set[`LSECB_E_FRAME] = rx_resp_reg;
            end
        end
        if (STOP_SAMPLE_IN & ~STOP_LEVEL_IN)
            err_set[`LSECB_E_FRAME] = 1'b1;
    end

    // sticky flags: set wins over the write-one clear
    always @*
    begin
        err_next = ERROR_FLAGS_OUT;
        if (FLAG_CLEAR_IN[`LSECB_F_ERR])
            err_next = 8'h00;
        err_next = err_next | err_set;
        ok_next = (FLAGS_OUT & ~FLAG_CLEAR_IN) | ok_set;
        ok_next[`LSECB_F_ERR] = |err_next;
    end

    // flags and interrupt requests
    always @(posedge CLK_SYS_IN)
    begin
        if (rst)
        begin
            ERROR_FLAGS_OUT <= 8'h00;
            FLAGS_OUT <= 4'h0;
            IRQ_COMPLETE_OUT <= 1'b0;
            IRQ_ERROR_OUT <= 1'b0;
        end
        else
        begin
            ERROR_FLAGS_OUT <= err_next;
            FLAGS_OUT <= ok_next;
            IRQ_COMPLETE_OUT <= |(ok_next[2:0] & IRQ_ENABLE_IN[2:0]);
            IRQ_ERROR_OUT <= ok_next[`LSECB_F_ERR] & IRQ_ENABLE_IN[`LSECB_F_ERR];
        end
    end

    // command field, response state, lengths and checksum
    always @(posedge CLK_SYS_IN)
    begin
        if (rst)
        begin
            COMMAND_OUT <= `LSECB_CMD_ABORT;
            RX_LENGTH_OUT <= `LSECB_LEN_ZERO;
            TX_LENGTH_OUT <= `LSECB_LEN_ZERO;
            FRAME_STATUS_OUT <= 3'h0;
            TX_ABORT_OUT <= 1'b0;
            rx_resp_reg <= 1'b0;
            tx_resp_reg <= 1'b0;
            sum_reg <= 8'h00;
            expect_reg <= `LSECB_LEN_MAX;
            bit_err_pend_reg <= 1'b0;
        end
        else
        begin
            TX_ABORT_OUT <= 1'b0;
            if (TX_BIT_CHECK_IN & (TX_BIT_SENT_IN != RX_BIT_IN))
                bit_err_pend_reg <= 1'b1;
            if (TX_BYTE_DONE_IN)
                bit_err_pend_reg <= 1'b0;
            if (CMD_WR_IN & BUSY_IN & (CMD_IN == `LSECB_CMD_ABORT))
                COMMAND_OUT <= `LSECB_CMD_ABORT;
            else if (cmd_ok)
            begin
                COMMAND_OUT <= CMD_IN;
                // checksum seed latched on every accepted command
                sum_reg <= sum_pid;
                if (~UART_MODE_IN & (CMD_IN == `LSECB_CMD_RX_RESP))
                begin
                    rx_resp_reg <= 1'b1;
                    RX_LENGTH_OUT <= rx_len_clamp;
                    expect_reg <= rx_len_clamp;
                    TX_LENGTH_OUT <= `LSECB_LEN_ZERO;
                end
                if (~UART_MODE_IN & (CMD_IN == `LSECB_CMD_TX_RESP))
                begin
                    tx_resp_reg <= 1'b1;
                    TX_LENGTH_OUT <= tx_len_clamp;
                    expect_reg <= tx_len_clamp;
                    RX_LENGTH_OUT <= `LSECB_LEN_ZERO;
                end
            end
            else if (LEN_WR_IN & ~BUSY_IN & ~UART_MODE_IN)
            begin
                RX_LENGTH_OUT <= LEN_WDATA_IN[3:0];
                TX_LENGTH_OUT <= LEN_WDATA_IN[7:4];
            end
            // header end: older protocol takes lengths from the identifier
            if (HDR_DONE_IN & ~UART_MODE_IN)
            begin
                if (PROTOCOL_OLD_IN)
                begin
                    RX_LENGTH_OUT <= old_len(PID_IN[5:4]);
                    TX_LENGTH_OUT <= old_len(PID_IN[5:4]);
                end
                if (PID_IN[5:2] == `LSECB_SPECIAL_ID)
                    FRAME_STATUS_OUT <= {1'b1, PID_IN[1:0]};
                else
                    FRAME_STATUS_OUT <= 3'h0;
            end
            // received data byte in a receive response
            if (take_byte & rx_resp_reg & ~UART_MODE_IN & (TX_LENGTH_OUT < expect_reg))
            begin
                sum_reg <= add_wrap(sum_reg, fifo_data);
                TX_LENGTH_OUT <= TX_LENGTH_OUT + 4'h1;
            end
            // sent data byte in a transmit response
            if (TX_BYTE_DONE_IN & tx_resp_reg & ~bit_err_pend_reg & (RX_LENGTH_OUT < expect_reg))
            begin
                sum_reg <= add_wrap(sum_reg, frame_buf[RX_LENGTH_OUT[2:0]]);
                RX_LENGTH_OUT <= RX_LENGTH_OUT + 4'h1;
            end
            if (ok_set[`LSECB_F_RXOK] | ok_set[`LSECB_F_TXOK])
            begin
                rx_resp_reg <= 1'b0;
                tx_resp_reg <= 1'b0;
            end
            // any lin error or break drops back to idle receive-header
            if (lin_err | (BREAK_SYNC_IN & ~UART_MODE_IN))
            begin
                COMMAND_OUT <= `LSECB_CMD_ABORT;
                rx_resp_reg <= 1'b0;
                tx_resp_reg <= 1'b0;
                TX_ABORT_OUT <= 1'b1;
            end
            if (UART_MODE_IN)
            begin
                RX_LENGTH_OUT <= `LSECB_LEN_ZERO;
                TX_LENGTH_OUT <= `LSECB_LEN_ZERO;
            end
        end
    end

    // next byte to send: data, then the inverted sum
    always @(posedge CLK_SYS_IN)
    begin
        if (rst)
            TX_DATA_OUT <= 8'h00;
        else if (UART_MODE_IN)
            TX_DATA_OUT <= uart_tx_reg;
        else if (RX_LENGTH_OUT < expect_reg)
            TX_DATA_OUT <= frame_buf[RX_LENGTH_OUT[2:0]];
        else
            TX_DATA_OUT <= `LSECB_CSUM_OK - sum_reg;
    end

    // frame time-out counter from the synch field on
    always @(posedge CLK_SYS_IN)
    begin
        if (rst)
        begin
            frame_run_reg <= 1'b0;
            bit_cnt_reg <= 12'h000;
        end
        else if (FRAME_START_IN & ~UART_MODE_IN)
        begin
            frame_run_reg <= 1'b1;
            bit_cnt_reg <= 12'h000;
        end
        else if (lin_err | ok_set[`LSECB_F_RXOK] | ok_set[`LSECB_F_TXOK])
            frame_run_reg <= 1'b0;
        else if (frame_run_reg & BIT_TICK_IN)
            bit_cnt_reg <= bit_cnt_reg + 12'h001;
    end

    // frame buffer, index and uart data holding
    always @(posedge CLK_SYS_IN)
    begin
        if (rst)
        begin
            INDEX_OUT <= 3'h0;
            DATA_RDATA_OUT <= 8'h00;
            uart_full_reg <= 1'b0;
            uart_rx_reg <= 8'h00;
            uart_tx_reg <= 8'h00;
        end
        else
        begin
            if (INDEX_WR_IN)
                INDEX_OUT <= INDEX_IN;
            else if ((DATA_RD_IN | data_wr_ok) & ~INC_DISABLE_N_IN & ~UART_MODE_IN)
                INDEX_OUT <= INDEX_OUT + 3'h1; // wraps 7 to 0
            if (DATA_RD_IN)
                DATA_RDATA_OUT <= UART_MODE_IN ? uart_rx_reg : frame_buf[INDEX_OUT];
            if (data_wr_ok & UART_MODE_IN)
                uart_tx_reg <= DATA_WDATA_IN;
            if (DATA_RD_IN & UART_MODE_IN)
                uart_full_reg <= 1'b0;
            if (take_byte & UART_MODE_IN)
            begin
                uart_rx_reg <= fifo_data;
                uart_full_reg <= 1'b1;
            end
        end
    end

    // buffer writes: software at the index, received byte n at slot n
    always @(posedge CLK_SYS_IN)
    begin
        if (data_wr_ok & ~UART_MODE_IN)
            frame_buf[INDEX_OUT] <= DATA_WDATA_IN;
        else if (take_byte & rx_resp_reg & ~UART_MODE_IN & (TX_LENGTH_OUT < expect_reg))
            frame_buf[TX_LENGTH_OUT[2:0]] <= fifo_data;
    end
endmodule // lsecb_top

// ===== src/lsecb_regs.vh
// constants for the lin status, error, checksum and buffer block
`ifndef LSECB_REGS_VH
`define LSECB_REGS_VH
// command field codes
`define LSECB_CMD_ABORT 3'h0
`define LSECB_CMD_TX_HDR 3'h1
`define LSECB_CMD_RX_RESP 3'h2
`define LSECB_CMD_TX_RESP 3'h3
// error flag positions
`define LSECB_E_BIT 0
`define LSECB_E_CSUM 1
`define LSECB_E_PAR 2
`define LSECB_E_SYNC 3
`define LSECB_E_FRAME 4
`define LSECB_E_TOUT 5
`define LSECB_E_OVR 6
`define LSECB_E_ABORT 7
// completion and error summary flag and enable positions
`define LSECB_F_RXOK 0
`define LSECB_F_TXOK 1
`define LSECB_F_IDOK 2
`define LSECB_F_ERR 3
// lengths, checksum target, special identifier prefix
`define LSECB_LEN_MAX 4'h8
`define LSECB_LEN_ZERO 4'h0
`define LSECB_CSUM_OK 8'hff
`define LSECB_SPECIAL_ID 4'hf
// frame time-out: header bits, bits per byte, 140 percent in tenths
`define LSECB_HDR_BITS 12'h022
`define LSECB_BYTE_BITS 12'h00a
`define LSECB_TO_TENTHS 12'h00e
`define LSECB_TENTHS 12'h00a
`endif

// ===== src/lsecb_fifo.v
// parameterised fifo carrying received bytes toward the frame buffer
`timescale 1ns/1ps
module lsecb_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // filling side
    input wire in_valid_in,
    output reg in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // draining side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg [AW:0] count_next;
    wire push;
    wire pop;

    // handshakes on both sides
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    assign out_valid_out = (count_reg != {(AW+1){1'b0}});
    assign out_data_out = mem[rd_ptr_reg];

    // occupancy after this cycle
    always @*
    begin
        count_next = count_reg;
        if (push & ~pop)
            count_next = count_reg + {{AW{1'b0}}, 1'b1};
        else if (pop & ~push)
            count_next = count_reg - {{AW{1'b0}}, 1'b1};
    end

    // pointers, count and registered ready
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            in_ready_out <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            count_reg <= count_next;
            in_ready_out <= (count_next < DEPTH); // honest full
        end
    end

    // storage
    always @(posedge clk_in)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data_in;
    end
endmodule // lsecb_fifo

// ===== verification/lsecb_link_model.sv
// far-side node model feeding received bytes over valid and ready
`timescale 1ns/1ps
module lsecb_link_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // byte stream toward the block
    input wire logic ready_in,
    output logic valid_out = 1'b0,
    output logic [7:0] byte_out = 8'h00
);
    logic [7:0] q[$];
    logic took = 1'b0;
    // queue one byte for sending
    task automatic send(input logic [7:0] b);
        q.push_back(b);
    endtask
    // remember whether the last rising edge took the byte
    always @(posedge clk_in)
        took <= valid_out & ready_in;
    // hold a byte until taken; an idle line inverts the last byte on every falling edge
    always @(negedge clk_in)
    begin
        if (rst_in)
            valid_out <= 1'b0;
        else if (!valid_out || took)
        begin
            valid_out <= q.size() != 0;
            byte_out <= (q.size() != 0) ? q.pop_front() : ~byte_out;
        end
    end
endmodule // lsecb_link_model

// ===== verification/lsecb_top_assertions.sv
// concurrent checks on the ports of the lin status, error and buffer block
`timescale 1ns/1ps
module lsecb_checker (
    // clock and resets
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic SW_RESET_IN,
    // watched inputs
    input wire logic UART_MODE_IN,
    input wire logic BUSY_IN,
    input wire logic CMD_WR_IN,
    input wire logic [2:0] CMD_IN,
    input wire logic [3:0] IRQ_ENABLE_IN,
    input wire logic [3:0] FLAG_CLEAR_IN,
    input wire logic STOP_SAMPLE_IN,
    input wire logic STOP_LEVEL_IN,
    input wire logic DATA_RD_IN,
    input wire logic INDEX_WR_IN,
    input wire logic INC_DISABLE_N_IN,
    // watched outputs
    input wire logic [2:0] COMMAND_OUT,
    input wire logic [3:0] RX_LENGTH_OUT,
    input wire logic [3:0] TX_LENGTH_OUT,
    input wire logic [3:0] FLAGS_OUT,
    input wire logic [7:0] ERROR_FLAGS_OUT,
    input wire logic [2:0] INDEX_OUT,
    input wire logic IRQ_COMPLETE_OUT,
    input wire logic IRQ_ERROR_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN || SW_RESET_IN);
    // abort while busy, then abort flag and idle command
    sequence s_abort_req;
        CMD_WR_IN && CMD_IN == 3'h0 && BUSY_IN;
    endsequence
    sequence s_abort_seen;
        ERROR_FLAGS_OUT[7] && COMMAND_OUT == 3'h0;
    endsequence
    a_abort_sets_flag: assert property (s_abort_req |=> s_abort_seen)
        else $error("abort while busy not flagged");
    a_summary_or_errors: assert property (FLAGS_OUT[3] == (|ERROR_FLAGS_OUT))
        else $error("summary flag differs from or of errors");
    a_irq_complete_gate: assert property (IRQ_COMPLETE_OUT == (|(FLAGS_OUT[2:0] & $past(IRQ_ENABLE_IN[2:0]))))
        else $error("completion request mismatch");
    a_irq_error_gate: assert property (IRQ_ERROR_OUT == (FLAGS_OUT[3] && $past(IRQ_ENABLE_IN[3])))
        else $error("error request mismatch");
    a_uart_len_zero: assert property (UART_MODE_IN && $past(UART_MODE_IN)
        |-> RX_LENGTH_OUT == 4'h0 && TX_LENGTH_OUT == 4'h0)
        else $error("length nonzero in uart mode");
    // a reset in the previous cycle may legally drop flags
    a_errors_sticky: assert property (!$past(FLAG_CLEAR_IN[3]) && !$past(RST_IN) && !$past(SW_RESET_IN)
        |-> (ERROR_FLAGS_OUT & $past(ERROR_FLAGS_OUT)) == $past(ERROR_FLAGS_OUT))
        else $error("error flag dropped without clear");
    a_stop_dominant: assert property (STOP_SAMPLE_IN && !STOP_LEVEL_IN |=> ERROR_FLAGS_OUT[4])
        else $error("dominant stop bit not flagged");
    a_overrun_busy: assert property (CMD_WR_IN && CMD_IN != 3'h0 && BUSY_IN && !UART_MODE_IN |=> ERROR_FLAGS_OUT[6])
        else $error("command while busy not flagged");
    a_index_advance: assert property (DATA_RD_IN && !INC_DISABLE_N_IN && !INDEX_WR_IN && !UART_MODE_IN
        |=> INDEX_OUT == $past(INDEX_OUT) + 3'h1)
        else $error("index did not advance");
endmodule // lsecb_checker
bind lsecb_top lsecb_checker i_lsecb_checker (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .SW_RESET_IN(SW_RESET_IN),
    .UART_MODE_IN(UART_MODE_IN), .BUSY_IN(BUSY_IN), .CMD_WR_IN(CMD_WR_IN), .CMD_IN(CMD_IN),
    .IRQ_ENABLE_IN(IRQ_ENABLE_IN), .FLAG_CLEAR_IN(FLAG_CLEAR_IN), .STOP_SAMPLE_IN(STOP_SAMPLE_IN),
    .STOP_LEVEL_IN(STOP_LEVEL_IN), .DATA_RD_IN(DATA_RD_IN), .INDEX_WR_IN(INDEX_WR_IN),
    .INC_DISABLE_N_IN(INC_DISABLE_N_IN), .COMMAND_OUT(COMMAND_OUT), .RX_LENGTH_OUT(RX_LENGTH_OUT),
    .TX_LENGTH_OUT(TX_LENGTH_OUT), .FLAGS_OUT(FLAGS_OUT), .ERROR_FLAGS_OUT(ERROR_FLAGS_OUT),
    .INDEX_OUT(INDEX_OUT), .IRQ_COMPLETE_OUT(IRQ_COMPLETE_OUT), .IRQ_ERROR_OUT(IRQ_ERROR_OUT));

// ===== verification/tb_top.sv
// self-checking bench for the lin status, error, checksum and buffer block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, sw_rst = 1'b0, uart = 1'b0, old = 1'b0, slave = 1'b0, busy = 1'b0;
    logic cmd_wr = 1'b0, len_wr = 1'b0, idx_wr = 1'b0, drd = 1'b0, dwr = 1'b0, hdr = 1'b0, sync_err = 1'b0;
    logic stop_s = 1'b0, stop_l = 1'b1, bchk = 1'b0, bsent = 1'b0, brx = 1'b0, bdone = 1'b0, zero = 1'b0;
    logic [2:0] cmd = 3'h0, idx = 3'h0, cmd_f, fstat, index;
    logic [3:0] irq_en = 4'h0, fclr = 4'h0, rxl, txl, flags;
    logic [7:0] len_wd = 8'h00, dwd = 8'h00, pid = 8'h00, errs, rdata, rx_byte, txd;
    logic rx_valid, rx_ready, irq_c, irq_e, abort_o, tdis = 1'b1, fstart = 1'b0, btick = 1'b0;
    int err_count = 0, checked = 0, cyc = 0;
    // clock at 4 ns period and a cycle ceiling
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_count++;
            results();
        end
    end
    lsecb_link_model i_lsecb_link_model (.clk_in(clk), .rst_in(rst), .ready_in(rx_ready), .valid_out(rx_valid),
        .byte_out(rx_byte));
    lsecb_top i_lsecb_top (.CLK_SYS_IN(clk), .RST_IN(rst), .SW_RESET_IN(sw_rst), .UART_MODE_IN(uart),
        .PROTOCOL_OLD_IN(old), .TIMEOUT_DISABLE_IN(tdis), .SLAVE_MODE_IN(slave), .IRQ_ENABLE_IN(irq_en),
        .CMD_WR_IN(cmd_wr), .CMD_IN(cmd), .BUSY_IN(busy), .LEN_WR_IN(len_wr), .LEN_WDATA_IN(len_wd),
        .FLAG_CLEAR_IN(fclr), .INDEX_WR_IN(idx_wr), .INDEX_IN(idx), .INC_DISABLE_N_IN(zero), .DATA_RD_IN(drd),
        .DATA_WR_IN(dwr), .DATA_WDATA_IN(dwd), .FRAME_START_IN(fstart), .BIT_TICK_IN(btick), .HDR_DONE_IN(hdr),
        .PID_IN(pid), .SYNC_TOL_ERR_IN(sync_err), .STOP_SAMPLE_IN(stop_s), .STOP_LEVEL_IN(stop_l),
        .TX_BIT_CHECK_IN(bchk), .TX_BIT_SENT_IN(bsent), .RX_BIT_IN(brx), .TX_BYTE_DONE_IN(bdone),
        .BREAK_SYNC_IN(zero), .RX_VALID_IN(rx_valid), .RX_BYTE_IN(rx_byte), .RX_READY_OUT(rx_ready),
        .COMMAND_OUT(cmd_f), .RX_LENGTH_OUT(rxl), .TX_LENGTH_OUT(txl), .FLAGS_OUT(flags),
        .ERROR_FLAGS_OUT(errs), .FRAME_STATUS_OUT(fstat), .INDEX_OUT(index), .DATA_RDATA_OUT(rdata),
        .TX_DATA_OUT(txd), .TX_ABORT_OUT(abort_o), .IRQ_COMPLETE_OUT(irq_c), .IRQ_ERROR_OUT(irq_e));
    // falling-edge steps, so every input change lands between rising edges
    task automatic nx(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic command(input logic [2:0] c);
        cmd = c;
        cmd_wr = 1'b1;
        nx(1);
        cmd_wr = 1'b0;
    endtask
    // header end with protected id, parity optionally spoiled
    task automatic header(input logic [5:0] id, input logic spoil);
        pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]) ^ spoil, id[0] ^ id[1] ^ id[2] ^ id[4], id};
        hdr = 1'b1;
        nx(1);
        hdr = 1'b0;
    endtask
    // eight-bit add with end-around carry
    function automatic logic [7:0] cadd(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = a + b;
        return s[7:0] + s[8];
    endfunction
    // two-byte receive response, checksum optionally off by one bit
    task automatic rx_resp(input logic [7:0] d0, input logic [7:0] d1, input logic bad);
        len_wd = 8'h02;
        len_wr = 1'b1;
        nx(1);
        len_wr = 1'b0;
        command(3'h2);
        busy = 1'b1;
        chk(txl, 8'h00);
        i_lsecb_link_model.send(d0);
        i_lsecb_link_model.send(d1);
        i_lsecb_link_model.send((8'hff - cadd(cadd(pid, d0), d1)) ^ bad);
        for (int n = 0; n < 60 && flags[0] !== 1'b1 && errs[1] !== 1'b1; n++)
            nx(1);
        busy = 1'b0;
    endtask
    task automatic pulse_rd();
        drd = 1'b1;
        nx(1);
        drd = 1'b0;
        nx(1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence of tests
    initial
    begin
        nx(5);
        rst = 1'b0;
        nx(1);
        chk({rxl, txl}, 8'h00);
        for (int n = 60; n < 65; n++)
        begin
            header(n[5:0], 1'b0);
            chk(fstat[2], n < 64);
            chk(fstat[1:0], (n < 64) ? n[1:0] : fstat[1:0]);
            chk({flags[2], errs[2]}, 8'h02);
        end
        header(6'h05, 1'b1);
        chk(errs[2], 8'h01);
        fclr = 4'hc;
        nx(1);
        fclr = 4'h0;
        old = 1'b1;
        header(6'h30, 1'b0);
        chk({rxl, txl}, 8'h88);
        header(6'h10, 1'b0);
        chk({rxl, txl}, 8'h22);
        old = 1'b0;
        $display("header tests done");
        irq_en = 4'hf;
        header(6'h05, 1'b0);
        rx_resp(8'h12, 8'hf0, 1'b0);
        chk({flags[0], errs}, 9'h100);
        chk({flags[0], txl, irq_c}, 8'h25);
        idx_wr = 1'b1;
        nx(1);
        idx_wr = 1'b0;
        pulse_rd();
        chk({rdata, index}, 11'h091);
        pulse_rd();
        chk({rdata, index}, 11'h782);
        fclr = 4'h1;
        header(6'h05, 1'b0);
        fclr = 4'h0;
        rx_resp(8'h12, 8'hf0, 1'b1);
        chk({errs[1], cmd_f, irq_e, abort_o}, 6'h23);
        irq_en = 4'h0;
        nx(1);
        chk(irq_e, 8'h00);
        fclr = 4'h8;
        nx(1);
        fclr = 4'h0;
        chk(errs, 8'h00);
        $display("response tests done");
        command(3'h3);
        bchk = 1'b1;
        bsent = 1'b1;
        nx(1);
        bchk = 1'b0;
        chk(errs[0], 8'h00);
        chk(txd, 8'h12);
        bdone = 1'b1;
        stop_s = 1'b1;
        stop_l = 1'b0;
        slave = 1'b1;
        sync_err = 1'b1;
        nx(1);
        {bdone, stop_s, stop_l, sync_err} = 4'h2;
        chk(errs[4:0], 8'h19);
        busy = 1'b1;
        command(3'h1);
        chk(errs[6], 8'h01);
        command(3'h0);
        busy = 1'b0;
        chk({errs[7], errs[4]}, 8'h03);
        command(3'h1);
        chk(cmd_f, 8'h01);
        sw_rst = 1'b1;
        nx(1);
        sw_rst = 1'b0;
        chk(errs, 8'h00);
        tdis = 1'b0;
        fstart = 1'b1;
        nx(1);
        {fstart, btick} = 2'h1;
        nx(174);
        chk(errs[5], 8'h00);
        nx(1);
        chk(errs[5], 8'h01);
        {btick, tdis} = 2'h1;
        $display("error tests done");
        uart = 1'b1;
        nx(1);
        len_wd = 8'h55;
        len_wr = 1'b1;
        nx(1);
        len_wr = 1'b0;
        chk({rxl, txl}, 8'h00);
        uart = 1'b0;
        dwr = 1'b1;
        for (int n = 0; n < 17; n++)
            i_lsecb_link_model.send(8'ha0 + n[7:0]);
        nx(30);
        chk(rx_ready, 8'h00);
        dwr = 1'b0;
        nx(40);
        chk(rx_ready, 8'h01);
        $display("buffer tests done");
        results();
    end
endmodule // tb_top
